/* File: design/exseq_map.svh */
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef EXSEQ_MAP_SVH
`define EXSEQ_MAP_SVH
// ==========================================================
// Register indices (byte address = 4 * index)
`define EXS_NREG 15
`define EXS_MSV 4'h0
`define EXS_SRA 4'h1
`define EXS_SRS 4'h2
`define EXS_FPC 4'h3
`define EXS_FCT 4'h4
`define EXS_LCA 4'h5
`define EXS_LCB 4'h6
`define EXS_ECA 4'h7
`define EXS_ECB 4'h8
`define EXS_DMC 4'h9
`define EXS_DMK 4'hA
`define EXS_CCS 4'hB
`define EXS_CAD 4'hC
`define EXS_CDT 4'hD
`define EXS_STA 4'hE
// ==========================================================
// Machine state vector bit positions (bit 0 is the LSB)
`define EXS_B_EE 15
`define EXS_B_PR 14
`define EXS_B_ME 12
`define EXS_B_IP 6
`define EXS_B_ILE 16
`define EXS_B_LE 0
// ==========================================================
// Values
`define EXS_ZERO 32'h0000_0000
`define EXS_LO_ZERO 16'h0000
`define EXS_DMK_SET 32'h2800_000F
`define EXS_BASE_LO 32'h0000_0000
`define EXS_BASE_HI 32'hFFF0_0000
`define EXS_VEC_RST 12'h100
// ==========================================================
// Timing in core clocks (50 MHz)
`define EXS_RESTORE_MAX 2'h3
`define EXS_FETCH_MIN 2'h2
`endif

/* File: design/exseq_pkg.sv */
// Types shared by the exception sequencer
`default_nettype none
package exseq_pkg;
  // ========================================================
  // Sequencer states, Gray coded along B -> D -> E
  typedef enum logic [1:0] {
    EXSEQ_IDLE = 2'b00,
    EXSEQ_RESTORE = 2'b01,
    EXSEQ_SAVE = 2'b11,
    EXSEQ_FETCH = 2'b10
  } exseq_state_t;
endpackage
`default_nettype wire

/* File: design/exseq_top.sv */
// Exception sequencer: retire, kill, restore, save, vector fetch, reset
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "exseq_map.svh"
module exseq_top
  import exseq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reset_req_i,
  input wire logic cfg_vbase_i,
  input wire logic hq_valid_i,
  input wire logic hq_exc_i,
  input wire logic hq_rfi_i,
  input wire logic [11:0] hq_vector_i,
  input wire logic [31:0] hq_addr_i,
  input wire logic [15:0] hq_info_i,
  input wire logic restore_done_i,
  input wire logic fetch_ack_i,
  output logic retire_o,
  output logic kill_o,
  output logic restore_o,
  output logic fetch_req_o,
  output logic [31:0] fetch_addr_o,
  output logic issue_o,
  output logic [31:0] msv_o
);

  // ========================================================
  // Helpers
  function automatic logic [31:0] vec_addr(input logic ip, input logic [11:0] vec);
    vec_addr = (ip ? `EXS_BASE_HI : `EXS_BASE_LO) | {20'h00000, vec};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // ========================================================
  // Declarations
  logic [31:0] spr [`EXS_NREG];
  exseq_state_t state;
  logic [1:0] rcnt;
  logic [1:0] fcnt;
  logic fetched;
  logic [31:0] exc_addr;
  logic [15:0] exc_info;
  logic rst_pend;
  logic rq_s1;
  logic rq_s2;
  logic rq_s3;
  logic cf_s1;
  logic cf_s2;
  logic reset_evt;
  logic bus_req;
  logic bus_wr;
  logic [3:0] bus_idx;
  logic bus_hit;
  logic [31:0] next_msv_exc;

  // ========================================================
  // Pin synchronisers
  always_ff @(posedge clk_i)
  begin
    rq_s1 <= reset_req_i;
    rq_s2 <= rq_s1;
    rq_s3 <= rq_s2;
    cf_s1 <= cfg_vbase_i;
    cf_s2 <= cf_s1;
  end

  // Power-on reset is turned into a reset exception on the next edge,
  // so the configuration bit can be applied by a clocked process.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rst_pend <= 1'b1;
    end
    else
    begin
      rst_pend <= 1'b0;
    end
  end

  assign reset_evt = rst_pend | (rq_s2 & ~rq_s3);

  // ========================================================
  // Bus decode
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign bus_idx = wb_adr_i[5:2];
  assign bus_hit = (wb_adr_i[7:6] == 2'b00) && (bus_idx < `EXS_STA);

  // New state on taking a non-reset exception
  always_comb
  begin
    next_msv_exc = spr[`EXS_MSV] & ~32'h0000_FFFF;
    next_msv_exc[`EXS_B_ME] = spr[`EXS_MSV][`EXS_B_ME];
    next_msv_exc[`EXS_B_IP] = spr[`EXS_MSV][`EXS_B_IP];
    next_msv_exc[`EXS_B_LE] = spr[`EXS_MSV][`EXS_B_ILE];
    next_msv_exc[`EXS_B_EE] = 1'b0;
    next_msv_exc[`EXS_B_PR] = 1'b0;
  end

  // ========================================================
  // Wishbone answer: one wait state, unmapped reads as zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `EXS_ZERO;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
      begin
        if (bus_hit)
        begin
          wb_dat_o <= spr[bus_idx];
        end
        else if (wb_adr_i[7:2] == {2'b00, `EXS_STA})
        begin
          wb_dat_o <= {27'h0000000, fetched, rst_pend, rcnt == 2'b00, state};
        end
        else
        begin
          wb_dat_o <= `EXS_ZERO;
        end
      end
    end
  end

  // ========================================================
  // Register file; hardware updates win over software writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < `EXS_NREG; i++)
      begin
        spr[i] <= `EXS_ZERO;
      end
    end
    else if (reset_evt)
    begin
      // Save and cache address/data regs left as they are: undefined
      spr[`EXS_MSV] <= `EXS_ZERO;
      spr[`EXS_MSV][`EXS_B_ME] <= spr[`EXS_MSV][`EXS_B_ME];
      spr[`EXS_MSV][`EXS_B_IP] <= cf_s2;
      spr[`EXS_FPC] <= `EXS_ZERO;
      spr[`EXS_FCT] <= `EXS_ZERO;
      spr[`EXS_LCA] <= `EXS_ZERO;
      spr[`EXS_LCB] <= `EXS_ZERO;
      spr[`EXS_ECA] <= {spr[`EXS_ECA][31:16], `EXS_LO_ZERO};
      spr[`EXS_ECB] <= {spr[`EXS_ECB][31:16], `EXS_LO_ZERO};
      spr[`EXS_DMC] <= `EXS_ZERO;
      spr[`EXS_DMK] <= spr[`EXS_DMK] | `EXS_DMK_SET;
      spr[`EXS_CCS] <= `EXS_ZERO;
    end
    else if (state == EXSEQ_SAVE)
    begin
      spr[`EXS_SRA] <= exc_addr;
      spr[`EXS_SRS] <= {exc_info, spr[`EXS_MSV][15:0]};
      spr[`EXS_MSV] <= next_msv_exc;
    end
    else if (state == EXSEQ_IDLE && hq_valid_i && !hq_exc_i && hq_rfi_i)
    begin
      // Younger work is killed and refetched, so it sees only this state
      spr[`EXS_MSV] <= {spr[`EXS_MSV][31:16], spr[`EXS_SRS][15:0]};
    end
    else if (bus_wr && bus_hit)
    begin
      spr[bus_idx] <= merge(spr[bus_idx], wb_dat_i, wb_sel_i);
    end
  end

  assign msv_o = spr[`EXS_MSV];

  // ========================================================
  // Latched cause of the exception being sequenced
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      exc_addr <= `EXS_ZERO;
      exc_info <= `EXS_LO_ZERO;
    end
    else if (state == EXSEQ_IDLE && hq_valid_i && hq_exc_i)
    begin
      exc_addr <= hq_addr_i;
      exc_info <= hq_info_i;
    end
  end

  // ========================================================
  // Sequencer: B recognise, B..D restore, D..E save, B..E fetch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= EXSEQ_IDLE;
      rcnt <= 2'b00;
      retire_o <= 1'b0;
      kill_o <= 1'b0;
      restore_o <= 1'b0;
      issue_o <= 1'b0;
    end
    else
    begin
      retire_o <= 1'b0;
      kill_o <= 1'b0;
      issue_o <= 1'b0;
      if (reset_evt)
      begin
        state <= EXSEQ_FETCH;
        kill_o <= 1'b1;
        restore_o <= 1'b0;
        rcnt <= 2'b00;
      end
      else
      begin
        case (state)
          EXSEQ_IDLE:
          begin
            if (hq_valid_i && hq_exc_i)
            begin
              // Head is complete and everything older finished cleanly
              kill_o <= 1'b1;
              restore_o <= 1'b1;
              rcnt <= 2'b01;
              state <= EXSEQ_RESTORE;
            end
            else if (hq_valid_i && hq_rfi_i)
            begin
              // Head position means every older instruction already retired
              retire_o <= 1'b1;
              kill_o <= 1'b1;
              state <= EXSEQ_FETCH;
            end
            else if (hq_valid_i)
            begin
              retire_o <= 1'b1;
            end
          end
          EXSEQ_RESTORE:
          begin
            // Forced end keeps the restore bounded even if the pipe is slow
            if (restore_done_i || rcnt == `EXS_RESTORE_MAX)
            begin
              restore_o <= 1'b0;
              rcnt <= 2'b00;
              state <= EXSEQ_SAVE;
            end
            else
            begin
              rcnt <= rcnt + 2'b01;
            end
          end
          EXSEQ_SAVE:
          begin
            state <= EXSEQ_FETCH;
          end
          EXSEQ_FETCH:
          begin
            if (fetched && fcnt >= `EXS_FETCH_MIN)
            begin
              issue_o <= 1'b1;
              state <= EXSEQ_IDLE;
            end
          end
          default:
          begin
            state <= EXSEQ_IDLE;
          end
        endcase
      end
    end
  end

  // ========================================================
  // Handler fetch request, started at recognition (time B)
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fetch_req_o <= 1'b0;
      fetch_addr_o <= `EXS_ZERO;
      fetched <= 1'b0;
      fcnt <= 2'b00;
    end
    else if (reset_evt)
    begin
      fetch_req_o <= 1'b1;
      fetch_addr_o <= vec_addr(cf_s2, `EXS_VEC_RST);
      fetched <= 1'b0;
      fcnt <= 2'b00;
    end
    else if (state == EXSEQ_IDLE && hq_valid_i && (hq_exc_i || hq_rfi_i))
    begin
      fetch_req_o <= 1'b1;
      fetched <= 1'b0;
      fcnt <= 2'b00;
      if (hq_exc_i)
      begin
        fetch_addr_o <= vec_addr(spr[`EXS_MSV][`EXS_B_IP], hq_vector_i);
      end
      else
      begin
        fetch_addr_o <= spr[`EXS_SRA];
      end
    end
    else
    begin
      if (fetch_req_o && fetch_ack_i)
      begin
        fetch_req_o <= 1'b0;
        fetched <= 1'b1;
      end
      if (state != EXSEQ_IDLE && fcnt != 2'b11)
      begin
        fcnt <= fcnt + 2'b01;
      end
    end
  end

endmodule
`default_nettype wire

/* File: test/exseq_top_chk.sv */
// Port assertions for the exception sequencer
`timescale 1ns/100ps
`default_nettype none
`include "exseq_map.svh"
module exseq_chk
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cfg_vbase_i,
  input wire logic hq_valid_i,
  input wire logic hq_exc_i,
  input wire logic [11:0] hq_vector_i,
  input wire logic retire_o,
  input wire logic kill_o,
  input wire logic restore_o,
  input wire logic fetch_req_o,
  input wire logic [31:0] fetch_addr_o,
  input wire logic issue_o,
  input wire logic [31:0] msv_o
);
  logic ip_q;
  logic [11:0] vec_q;
  // ==========================================================
  // Values of the take cycle, for the vector check one cycle on
  always_ff @(posedge clk_i)
  begin
    ip_q <= msv_o[`EXS_B_IP];
    vec_q <= hq_vector_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Assertions
  retire_clean_a: assert property (retire_o |-> $past(hq_valid_i && !hq_exc_i))
    else $error("retire without clean head");
  kill_start_a: assert property ($rose(restore_o) |-> kill_o && fetch_req_o)
    else $error("restore without kill");
  restore_len_a: assert property ($rose(restore_o) |-> ##[1:3] !restore_o)
    else $error("restore too long");
  save_gap_a: assert property (issue_o |-> !restore_o && !$past(restore_o))
    else $error("no save cycle");
  fetch_min_a: assert property ($rose(fetch_req_o) |-> !issue_o ##1 !issue_o)
    else $error("fetch too short");
  kill_pulse_a: assert property (kill_o |=> !kill_o)
    else $error("kill not a pulse");
  vector_addr_a: assert property ($rose(fetch_req_o) && $past(hq_valid_i && hq_exc_i)
    |-> fetch_addr_o == ((ip_q ? `EXS_BASE_HI : `EXS_BASE_LO) | {20'h0, vec_q}))
    else $error("wrong vector address");
  reset_vec_a: assert property ($fell(rst_i) |=> kill_o && fetch_req_o
    && fetch_addr_o == ((cfg_vbase_i ? `EXS_BASE_HI : `EXS_BASE_LO) | 32'h0000_0100))
    else $error("wrong reset vector");
endmodule
bind exseq_top exseq_chk chk_u (.clk_i, .rst_i, .cfg_vbase_i, .hq_valid_i, .hq_exc_i,
  .hq_vector_i, .retire_o, .kill_o, .restore_o, .fetch_req_o, .fetch_addr_o, .issue_o, .msv_o);
`default_nettype wire

/* File: test/exseq_fetch_mem.sv */
// Handler fetch memory model answering fetch requests
`timescale 1ns/100ps
`default_nettype none
module exseq_fetch_mem
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [3:0] wait_i,
  output logic ack_o
);
  logic [3:0] cnt;
  // ==========================================================
  // Latency set per scenario, so prompt and slow answers occur
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !req_i)
    begin
      cnt <= 4'h0;
      ack_o <= 1'b0;
    end
    else if (ack_o)
      ack_o <= 1'b0;
    else if (cnt == wait_i)
      ack_o <= 1'b1;
    else
      cnt <= cnt + 4'h1;
  end
endmodule
`default_nettype wire

/* File: test/test_exception_sequencer.sv */
// Self-checking bench for the exception sequencer
`timescale 1ns/100ps
`default_nettype none
`include "exseq_map.svh"
module test_exception_sequencer
  import exseq_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i, wb_cyc_i, wb_stb_i, wb_we_i, reset_req_i, cfg_vbase_i;
  logic hq_valid_i, hq_exc_i, hq_rfi_i, restore_done_i, fetch_ack_i;
  logic wb_ack_o, retire_o, kill_o, restore_o, fetch_req_o, issue_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, mem_wait;
  logic [11:0] hq_vector_i;
  logic [15:0] hq_info_i;
  logic [31:0] wb_dat_i, wb_dat_o, hq_addr_i, fetch_addr_o, msv_o, rd, fa;
  int n_fail = 0;
  int tests_run = 0;
  exseq_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .reset_req_i, .cfg_vbase_i, .hq_valid_i, .hq_exc_i,
    .hq_rfi_i, .hq_vector_i, .hq_addr_i, .hq_info_i, .restore_done_i, .fetch_ack_i,
    .retire_o, .kill_o, .restore_o, .fetch_req_o, .fetch_addr_o, .issue_o, .msv_o);
  exseq_fetch_mem mem_u (.clk_i, .rst_i, .req_i(fetch_req_o), .wait_i(mem_wait),
    .ack_o(fetch_ack_i));
  always #10 clk_i = ~clk_i;
  // Last requested fetch target
  always @(negedge clk_i) if (fetch_req_o === 1'b1) fa = fetch_addr_o;
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [3:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= {2'b00, idx, 2'b00};
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    // No cycle limit here; a hang is ended by the watchdog
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task automatic offer(input logic exc, input logic rfi);
    @(posedge clk_i);
    {hq_valid_i, hq_exc_i, hq_rfi_i} <= {1'b1, exc, rfi};
    @(posedge clk_i);
    {hq_valid_i, hq_exc_i, hq_rfi_i} <= 3'b000;
    @(negedge clk_i);
  endtask
  task automatic run_to_issue(input logic [31:0] exp_fa);
    int n = 0;
    do @(negedge clk_i); while (issue_o !== 1'b1 && n++ < 60);
    chk("issue", 1, issue_o);
    chk("fetch addr", exp_fa, fa);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset_state;
    run_to_issue(32'h0000_0100);
    wb(0, `EXS_MSV, 0);
    chk("msv", 0, rd);
    wb(0, `EXS_DMK, 0);
    chk("dmask", `EXS_DMK_SET, rd);
  endtask
  task automatic t_exc;
    wb(1, `EXS_MSV, 32'h0001_C040);
    hq_vector_i <= 12'h700;
    hq_addr_i <= 32'h1234_5678;
    hq_info_i <= 16'hABCD;
    mem_wait <= 4'h0;
    offer(1, 0);
    chk("kill", 1, kill_o);
    chk("retire", 0, retire_o);
    run_to_issue(32'hFFF0_0700);
    wb(0, `EXS_SRA, 0);
    chk("save_restore_addr", 32'h1234_5678, rd);
    wb(0, `EXS_SRS, 0);
    chk("save_restore_state", 32'hABCD_C040, rd);
    wb(0, `EXS_MSV, 0);
    chk("msv", 32'h0001_0041, rd);
    chk("msv out", 32'h0001_0041, msv_o);
  endtask
  task automatic t_rfi;
    offer(0, 0);
    chk("retire", 1, retire_o);
    chk("kill", 0, kill_o);
    offer(0, 1);
    chk("retire", 1, retire_o);
    chk("kill", 1, kill_o);
    run_to_issue(32'h1234_5678);
    wb(0, `EXS_MSV, 0);
    chk("msv", 32'h0001_C040, rd);
  endtask
  task automatic t_reset_req;
    for (int i = 3; i < 12; i++)
      wb(1, i[3:0], i == 10 ? 32'h0 : 32'hFFFF_FFFF);
    cfg_vbase_i <= 1'b1;
    mem_wait <= 4'h9;
    wb(1, `EXS_MSV, 32'h0000_D000);
    offer(1, 0);
    @(posedge clk_i);
    reset_req_i <= 1'b1;
    run_to_issue(32'hFFF0_0100);
    @(posedge clk_i);
    reset_req_i <= 1'b0;
    wb(0, `EXS_MSV, 0);
    chk("msv", 32'h0000_1040, rd);
    for (int i = 3; i < 12; i++)
    begin
      wb(0, i[3:0], 0);
      chk("reg", i == 10 ? `EXS_DMK_SET : (i == 7 || i == 8) ? 32'hFFFF_0000 : 0, rd);
    end
  endtask
  // Pipeline reports restore done early: restore ends one cycle after take
  task automatic t_fast_restore;
    restore_done_i <= 1'b1;
    mem_wait <= 4'h1;
    offer(1, 0);
    chk("restore", 1, restore_o);
    @(negedge clk_i);
    chk("restore", 0, restore_o);
    run_to_issue(32'hFFF0_0700);
    chk("msv out", 32'h0000_1040, msv_o);
    wb(0, `EXS_SRS, 0);
    restore_done_i <= 1'b0;
    chk("save_restore_state", 32'hABCD_1040, rd);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    {rst_i, wb_sel_i, mem_wait} = {1'b1, 4'hF, 4'h2};
    {wb_cyc_i, wb_stb_i, wb_we_i, reset_req_i, cfg_vbase_i} = '0;
    {hq_valid_i, hq_exc_i, hq_rfi_i, restore_done_i} = '0;
    {wb_adr_i, wb_dat_i, hq_vector_i, hq_addr_i, hq_info_i} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_state();
    t_exc();
    t_rfi();
    t_reset_req();
    t_fast_restore();
    report_and_stop();
  end
  initial
  begin
    repeat (4000) @(posedge clk_i);
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
